// file: hw/dcf_pkg.sv
package dcf_pkg;
    localparam int DCF_WIDTH = 9;
    localparam int DCF_DEPTH = 16384;
    localparam int DCF_AW    = 14;
    localparam int DCF_CW    = 15;

    // Offset registers and their reset value.
    localparam logic [DCF_CW-1:0] DCF_OFFSET_RESET = 15'h0007;

    // APB register byte addresses.
    localparam logic [7:0] DCF_ADDR_AE_OFFSET = 8'h00;
    localparam logic [7:0] DCF_ADDR_AF_OFFSET = 8'h04;
    localparam logic [7:0] DCF_ADDR_STATUS    = 8'h08;
    localparam logic [7:0] DCF_ADDR_INT_STAT  = 8'h0C;
    localparam logic [7:0] DCF_ADDR_INT_MASK  = 8'h10;

    // Status register fields.
    localparam int DCF_ST_COUNT_LSB = 0;
    localparam int DCF_ST_EMPTY_N   = 16;
    localparam int DCF_ST_AEMPTY_N  = 17;
    localparam int DCF_ST_AFULL_N   = 18;
    localparam int DCF_ST_FULL_N    = 19;
    localparam int DCF_ST_MODE      = 20;

    // Interrupt event bits.
    localparam int DCF_NUM_EV     = 4;
    localparam int DCF_EV_WR_DROP = 0;
    localparam int DCF_EV_RD_DROP = 1;
    localparam int DCF_EV_FULL    = 2;
    localparam int DCF_EV_EMPTY   = 3;
    localparam logic [DCF_NUM_EV-1:0] DCF_MASK_RESET = 4'h0;

    // Role of the shared write-enable-two / load pin.
    typedef enum logic {DCF_ROLE_LOAD, DCF_ROLE_WRITE_ENABLE} dcf_role_t;
endpackage

// file: hw/dcf_fifo.sv
// What this block does
// - Full flag releases on the same edge as the read.
// - Reset works with clocks still running.
// - Outputs driven one cycle after enable, released otherwise.
// - Pin level at reset selects enable or load.
// - First word appears on the first read after empty clears.
// - Empty release latency at most two cycles.
// - Almost-empty asserts below empty offset words.
// - Almost-full asserts at depth minus offset plus one.
// - Almost-full threshold is depth minus offset.
// - Almost-empty changes on the same edge as the count.
// - Almost-full changes on the same edge as the count.
// - Full flag blocks all writes.
// - Empty flag blocks all reads.
// - Both offsets reset to seven words.
module dcf_fifo
    import dcf_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // Write port.
    input  wire logic [DCF_WIDTH-1:0]  write_data,
    input  wire logic                  write_enable_n,
    input  wire logic                  write_enable_two_or_load,
    // Read port.
    input  wire logic                  read_enable_n,
    input  wire logic                  read_enable_two_n,
    input  wire logic                  output_enable_n,
    output logic [DCF_WIDTH-1:0]       read_data,
    output logic                       read_data_oe,
    // Flags.
    output logic                       full_flag_n,
    output logic                       empty_flag_n,
    output logic                       almost_empty_flag_n,
    output logic                       almost_full_flag_n,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Interrupt.
    output logic                       irq
);

    logic [DCF_WIDTH-1:0]  mem [DCF_DEPTH];
    logic [DCF_AW-1:0]     wr_ptr_reg;
    logic [DCF_AW-1:0]     rd_ptr_reg;
    logic [DCF_CW-1:0]     count_reg;
    logic [DCF_CW-1:0]     count_next;
    logic [DCF_CW-1:0]     ae_offset_reg;
    logic [DCF_CW-1:0]     af_offset_reg;
    logic [DCF_NUM_EV-1:0] int_stat_reg;
    logic [DCF_NUM_EV-1:0] int_mask_reg;
    logic [DCF_NUM_EV-1:0] ev_pulse;
    logic [31:0]           rdata_next;
    logic                  addr_ok;
    dcf_role_t             role_reg;
    logic                  wr_req;
    logic                  rd_req;
    logic                  wr_do;
    logic                  rd_do;
    logic                  apb_done;
    logic                  apb_wr;

    // Write is enabled by the second pin only in its enable role.
    always_comb
    begin
        wr_req = !write_enable_n &&
                 ((role_reg == DCF_ROLE_LOAD) || write_enable_two_or_load);
        rd_req = !read_enable_n && !read_enable_two_n;
        wr_do  = wr_req && full_flag_n;
        rd_do  = rd_req && empty_flag_n;
        case ({wr_do, rd_do})
            2'b10:   count_next = count_reg + 15'h0001;
            2'b01:   count_next = count_reg - 15'h0001;
            default: count_next = count_reg;
        endcase
    end

    // The pin role is captured every reset cycle, so running clocks are harmless.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            role_reg <= write_enable_two_or_load ? DCF_ROLE_WRITE_ENABLE
                                                 : DCF_ROLE_LOAD;
        end
    end

    // Storage array.
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && wr_do)
        begin
            mem[wr_ptr_reg] <= write_data;
        end
    end

    // Write pointer, read pointer and fill count, one process each.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
        end
        else if (clk_en && wr_do)
        begin
            wr_ptr_reg <= wr_ptr_reg + 14'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_ptr_reg <= '0;
        end
        else if (clk_en && rd_do)
        begin
            rd_ptr_reg <= rd_ptr_reg + 14'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg <= '0;
        end
        else if (clk_en)
        begin
            count_reg <= count_next;
        end
    end

    // Read data: the first word follows one read after empty clears.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            read_data    <= '0;
            read_data_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            read_data_oe <= !output_enable_n;
            if (rd_do)
            begin
                read_data <= mem[rd_ptr_reg];
            end
        end
    end

    // Flags follow the new count on the same edge; one clock leaves no skew slip.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            empty_flag_n <= 1'b0;
        end
        else if (clk_en)
        begin
            empty_flag_n <= count_next != '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            full_flag_n <= 1'b1;
        end
        else if (clk_en)
        begin
            full_flag_n <= count_next != DCF_CW'(DCF_DEPTH);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            almost_empty_flag_n <= 1'b0;
        end
        else if (clk_en)
        begin
            almost_empty_flag_n <= !(count_next < ae_offset_reg);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            almost_full_flag_n <= 1'b1;
        end
        else if (clk_en)
        begin
            almost_full_flag_n <= !(count_next >
                                    DCF_CW'(DCF_DEPTH) - af_offset_reg);
        end
    end

    // APB: one wait state, answer in the second access cycle.
    always_comb
    begin
        apb_done = psel && penable && pready;
        apb_wr   = apb_done && pwrite && !pslverr;
        addr_ok  = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            DCF_ADDR_AE_OFFSET: rdata_next[DCF_CW-1:0] = ae_offset_reg;
            DCF_ADDR_AF_OFFSET: rdata_next[DCF_CW-1:0] = af_offset_reg;
            DCF_ADDR_STATUS:
            begin
                rdata_next[DCF_ST_COUNT_LSB +: DCF_CW] = count_reg;
                rdata_next[DCF_ST_EMPTY_N]  = empty_flag_n;
                rdata_next[DCF_ST_AEMPTY_N] = almost_empty_flag_n;
                rdata_next[DCF_ST_AFULL_N]  = almost_full_flag_n;
                rdata_next[DCF_ST_FULL_N]   = full_flag_n;
                rdata_next[DCF_ST_MODE]     = (role_reg == DCF_ROLE_WRITE_ENABLE);
            end
            DCF_ADDR_INT_STAT:  rdata_next[DCF_NUM_EV-1:0] = int_stat_reg;
            DCF_ADDR_INT_MASK:  rdata_next[DCF_NUM_EV-1:0] = int_mask_reg;
            default:            addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            if (psel && penable && !pready && !pwrite)
            begin
                prdata <= rdata_next;
            end
        end
    end

    // Offsets are writable only while the shared pin is in its load role.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ae_offset_reg <= DCF_OFFSET_RESET;
            af_offset_reg <= DCF_OFFSET_RESET;
            int_mask_reg  <= DCF_MASK_RESET;
        end
        else if (clk_en && apb_wr)
        begin
            if (paddr == DCF_ADDR_AE_OFFSET && role_reg == DCF_ROLE_LOAD)
            begin
                ae_offset_reg <= pwdata[DCF_CW-1:0];
            end
            if (paddr == DCF_ADDR_AF_OFFSET && role_reg == DCF_ROLE_LOAD)
            begin
                af_offset_reg <= pwdata[DCF_CW-1:0];
            end
            if (paddr == DCF_ADDR_INT_MASK)
            begin
                int_mask_reg <= pwdata[DCF_NUM_EV-1:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear.
    always_comb
    begin
        ev_pulse                 = '0;
        ev_pulse[DCF_EV_WR_DROP] = wr_req && !full_flag_n;
        ev_pulse[DCF_EV_RD_DROP] = rd_req && !empty_flag_n;
        ev_pulse[DCF_EV_FULL]    = full_flag_n && count_next == DCF_CW'(DCF_DEPTH);
        ev_pulse[DCF_EV_EMPTY]   = empty_flag_n && count_next == '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            int_stat_reg <= '0;
            irq          <= 1'b0;
        end
        else if (clk_en)
        begin
            int_stat_reg <= (int_stat_reg &
                             ~((apb_wr && paddr == DCF_ADDR_INT_STAT)
                               ? pwdata[DCF_NUM_EV-1:0] : 4'h0)) | ev_pulse;
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

endmodule

// file: testbench/dcf_fifo_properties.sv
module dcf_fifo_properties
    import dcf_pkg::*;
(
    // Clock and control.
    input wire logic                 sys_clk, rst, clk_en, output_enable_n,
    input wire logic                 write_enable_n, write_enable_two_or_load,
    input wire logic                 read_enable_n, read_enable_two_n,
    // Observed outputs.
    input wire logic [DCF_WIDTH-1:0] read_data,
    input wire logic                 read_data_oe, full_flag_n, empty_flag_n,
    input wire logic                 almost_empty_flag_n, almost_full_flag_n,
    input wire logic                 psel, penable, pready, pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DCF_CW-1:0] cnt_reg;
    wire logic wr_ok = clk_en && !write_enable_n && write_enable_two_or_load && full_flag_n;
    wire logic rd_ok = clk_en && !read_enable_n && !read_enable_two_n && empty_flag_n;

    // Shadow word count built from the taken reads and from the writes taken with the second pin high.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + DCF_CW'(wr_ok) - DCF_CW'(rd_ok);
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_empty; empty_flag_n == (cnt_reg != 0); endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");
    property p_full; full_flag_n == (cnt_reg != DCF_DEPTH); endproperty
    a_full: assert property (p_full) else $error("full flag wrong");
    property p_ae; almost_empty_flag_n == (cnt_reg >= DCF_OFFSET_RESET); endproperty
    a_ae: assert property (p_ae) else $error("almost empty wrong");
    property p_af; almost_full_flag_n == (cnt_reg <= DCF_DEPTH - DCF_OFFSET_RESET); endproperty
    a_af: assert property (p_af) else $error("almost full wrong");
    property p_rst; disable iff (1'b0) rst |=> !empty_flag_n && !almost_empty_flag_n
        && full_flag_n && almost_full_flag_n && read_data == '0 && !read_data_oe; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_oe; clk_en |=> read_data_oe == !$past(output_enable_n); endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_rdy; $rose(penable) && psel && clk_en |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_hold; !full_flag_n && read_enable_n |=> !full_flag_n; endproperty
    a_hold: assert property (p_hold) else $error("write taken while full");
endmodule

// file: testbench/dcf_producer.sv
module dcf_producer
    import dcf_pkg::*;
(
    // Control and flag.
    input  wire logic                 sys_clk,
    input  wire logic                 go,
    input  wire logic                 full_flag_n,
    // Write port.
    output logic [DCF_WIDTH-1:0]      write_data,
    output logic                      write_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial write_data = 9'h001;
    initial write_enable_n = 1'h1;
    // A word advances only when the device takes it.
    always @(posedge sys_clk)
    begin
        if (!write_enable_n && full_flag_n)
            write_data <= write_data + 9'h001;
        write_enable_n <= !go;
    end
endmodule

// file: testbench/dcf_fifo_tb.sv
module dcf_fifo_tb
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, rst = 1'h1, go = 1'h0, ren_n = 1'h1, oe_n = 1'h1, wel = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [8:0] wd, rdat, exp;
    logic we_n, rdoe, full_n, empty_n, aempty_n, afull_n;
    int err_count = 0, total_checks = 0, i;

    dcf_producer prod (.sys_clk(sys_clk), .go(go), .full_flag_n(full_n), .write_data(wd),
        .write_enable_n(we_n));
    dcf_fifo uut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1), .write_data(wd),
        .write_enable_n(we_n), .write_enable_two_or_load(wel), .read_enable_n(ren_n),
        .read_enable_two_n(ren_n), .output_enable_n(oe_n), .read_data(rdat),
        .read_data_oe(rdoe), .full_flag_n(full_n), .empty_flag_n(empty_n),
        .almost_empty_flag_n(aempty_n), .almost_full_flag_n(afull_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    initial forever #2 sys_clk = ~sys_clk;

    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        total_checks++;
        if (got !== x)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do
            @(posedge sys_clk);
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(r, x);
    endtask

    // Holds reads enabled for n plus one edges and compares the first n words with a running sequence.
    task automatic drain(input int n, input logic [8:0] s);
        exp = s;
        @(posedge sys_clk) ren_n <= 1'h0;
        for (i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            #1 chk(rdat, exp);
            exp++;
        end
        @(posedge sys_clk) ren_n <= 1'h1;
    endtask

    initial
    begin
        #200000 err_count++;
        finish_test();
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        oe_n <= 1'h0;
        @(posedge sys_clk);
        #1 chk(rdat, 32'h0);
        chk(rdoe, 32'h1);
        rd(DCF_ADDR_AE_OFFSET, 32'h7);
        rd(DCF_ADDR_AF_OFFSET, 32'h7);
        rd(DCF_ADDR_STATUS, 32'h001C0000);
        apb(1'h1, DCF_ADDR_AE_OFFSET, 32'h3);
        rd(DCF_ADDR_AE_OFFSET, 32'h7);
        rd(8'h20, 32'h0);
        chk(e, 32'h1);
        @(posedge sys_clk) ren_n <= 1'h0;
        @(posedge sys_clk) ren_n <= 1'h1;
        apb(1'h0, DCF_ADDR_INT_STAT, 32'h0);
        chk(r[DCF_EV_RD_DROP], 32'h1);
        apb(1'h1, DCF_ADDR_INT_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        #1 chk(irq, 32'h1);
        apb(1'h1, DCF_ADDR_INT_STAT, 32'h2);
        repeat (2) @(posedge sys_clk);
        #1 chk(irq, 32'h0);
        @(posedge sys_clk) go <= 1'h1;
        @(posedge sys_clk) go <= 1'h0;
        for (i = 0; i < 3 && empty_n !== 1'h1; i++) @(posedge sys_clk);
        chk(empty_n, 32'h1);
        drain(1, 9'h001);
        @(posedge sys_clk) go <= 1'h1;
        for (i = 0; i < 20000 && full_n !== 1'h0; i++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        go <= 1'h0;
        rd(DCF_ADDR_STATUS, 32'h00134000);
        apb(1'h0, DCF_ADDR_INT_STAT, 32'h0);
        chk(r[DCF_EV_WR_DROP], 32'h1);
        drain(DCF_DEPTH, 9'h002);
        chk(empty_n, 32'h0);
        rst <= 1'h1;
        wel <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        rd(DCF_ADDR_STATUS, 32'h000C0000);
        apb(1'h1, DCF_ADDR_AE_OFFSET, 32'h3);
        rd(DCF_ADDR_AE_OFFSET, 32'h3);
        finish_test();
    end
endmodule

bind dcf_fifo dcf_fifo_properties u_props (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .write_enable_two_or_load(write_enable_two_or_load), .read_enable_n(read_enable_n),
    .read_enable_two_n(read_enable_two_n), .read_data(read_data),
    .read_data_oe(read_data_oe), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr));
